// ---- dv/pin_source.sv ----
// stand-in for the asynchronous signals wired to the gpio pins
// assumes the bench sets the tested pins; the rest chatter freely
`timescale 1ns/1ps
`default_nettype none

module pin_source (
  input  wire logic        pclk,       // system clock
  input  wire logic        presetn,    // async reset, active low
  input  wire logic [15:0] level_set,  // level asked of the quiet pins
  input  wire logic [15:0] quiet_mask, // pins that follow level_set
  output logic      [15:0] pin_in      // pin levels into the design
);
  logic [15:0] chatter_reg;

  // ----------------------------------------------------------------
  // untested pins
  // ----------------------------------------------------------------
  // toggle every cycle so no stale level can hide a leak between pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chatter_reg <= 16'h5a5a;
    end else begin
      chatter_reg <= ~chatter_reg;
    end
  end

  // tested pins follow the bench at once, glitches and all
  assign pin_in = (level_set & quiet_mask) | (chatter_reg & ~quiet_mask);
endmodule

`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench for the gpio input qualifier
// assumes pin_source drives the pins and apb is mastered here
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end

module testbench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] pin_in;
  logic [15:0] pin_qualified;
  logic [31:0] pin_function;
  logic [15:0] level_set;
  logic [15:0] quiet_mask;
  logic [31:0] rdv;
  logic        erv;
  int          n_mismatch;
  int          samples_checked;

  // ----------------------------------------------------------------
  // clock and instances
  // ----------------------------------------------------------------
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  gpio_input_qualifier u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_qualified(pin_qualified), .pin_function(pin_function));

  pin_source u_pins (.pclk(pclk), .presetn(presetn), .level_set(level_set),
    .quiet_mask(quiet_mask), .pin_in(pin_in));

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  // leading edge wait keeps two transfers from assigning psel in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no wait-state count is assumed; a hang is left to the watchdog
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
    `CHK("wr_err", 1'b0, er)
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic ee, input string nm);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, rd, er);
    `CHK(nm, e, rd)
    `CHK(nm, ee, er)
  endtask

  // glitch one window long is dropped; a steady level lands inside its bounds
  task automatic qual(input int pin, input int s, input int n);
    int p;
    int w;
    p = (n == 0) ? 1 : 2 * n;
    w = p * (s - 1);
    @(posedge pclk);
    level_set[pin] <= 1'b1;
    repeat (w) @(posedge pclk);
    level_set[pin] <= 1'b0;
    repeat (w + p + 4) @(posedge pclk);
    #1 `CHK("glitch", 1'b0, pin_qualified[pin])
    @(posedge pclk);
    level_set[pin] <= 1'b1;
    repeat (w + 3) @(posedge pclk);
    #1 `CHK("early", 1'b0, pin_qualified[pin])
    repeat (p) @(posedge pclk);
    #1 `CHK("late", 1'b1, pin_qualified[pin])
    @(posedge pclk);
    level_set[pin] <= 1'b0;
    repeat (w + p + 4) @(posedge pclk);
    #1 `CHK("fall", 1'b0, pin_qualified[pin])
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog, well past the roughly 18k cycles the tests take
  // ----------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    $display("watchdog expired");
    print_verdict();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    level_set = 16'h0000;
    quiet_mask = 16'h030f;
    presetn = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(gpio_qual_pkg::OFS_PORT_CTRL, gpio_qual_pkg::RST_PORT_CTRL, 1'b0, "ctrl_rst");
    rd_chk(gpio_qual_pkg::OFS_QSEL, gpio_qual_pkg::RST_QSEL, 1'b0, "qsel_rst");
    rd_chk(8'h10, 32'h0, 1'b1, "unmapped");
    `CHK("func_rst", gpio_qual_pkg::RST_FUNC, pin_function)
    $display("test reset done");
    // pin-function select is seen by logic at the second edge after the write edge
    wr_reg(gpio_qual_pkg::OFS_FUNC, 32'ha5a5_3c3c);
    #1 `CHK("func_e1", 32'h0, pin_function)
    @(posedge pclk);
    #1 `CHK("func_e2", 32'ha5a5_3c3c, pin_function)
    rd_chk(gpio_qual_pkg::OFS_FUNC, 32'ha5a5_3c3c, 1'b0, "func_rd");
    $display("test apply delay done");
    // pins 0,8 three samples; 1,9 six samples; pin 2 raw bypass
    wr_reg(gpio_qual_pkg::OFS_QSEL, 32'h0009_0039);
    rd_chk(gpio_qual_pkg::OFS_QSEL, 32'h0009_0039, 1'b0, "qsel_rd");
    repeat (4) @(posedge pclk);
    level_set[2] <= 1'b1;
    #1 `CHK("bypass_hi", 1'b1, pin_qualified[2])
    @(posedge pclk);
    level_set[2] <= 1'b0;
    #1 `CHK("bypass_lo", 1'b0, pin_qualified[2])
    $display("test bypass done");
    // two groups with different fields, the largest one included
    for (int k = 0; k < 2; k++) begin
      wr_reg(gpio_qual_pkg::OFS_PORT_CTRL, (k == 0) ? 32'h0000_0002 : 32'h0000_ff00);
      qual(0, 3, (k == 0) ? 2 : 0);
      qual(1, 6, (k == 0) ? 2 : 0);
      qual(8, 3, (k == 0) ? 0 : 255);
      qual(9, 6, (k == 0) ? 0 : 255);
      $display("test qualification set %0d done", k);
    end
    // level register shows the quiet pins; only pin 3 (plain sync) is high
    @(posedge pclk);
    level_set[3] <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, gpio_qual_pkg::OFS_LEVEL, 32'h0, rdv, erv);
    `CHK("level_rd", 32'h0000_0008, rdv & {16'hffff, quiet_mask})
    `CHK("level_err", 1'b0, erv)
    $display("test level read done");
    print_verdict();
  end
endmodule

`default_nettype wire

// ---- hdl/gpio_input_qualifier.sv ----
// gpio input qualifier: apb registers, group sample timers, per-pin cells
// assumes an apb master on pclk and asynchronous pins
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module gpio_input_qualifier (
  input  wire logic        pclk,          // system clock, 25 mhz
  input  wire logic        presetn,       // async reset, active low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb direction
  input  wire logic [7:0]  paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic [31:0]      prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error on unmapped address
  input  wire logic [15:0] pin_in,        // asynchronous pins
  output logic [15:0]      pin_qualified, // qualified levels
  output logic [31:0]      pin_function   // applied pin-function select
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic        setup;
  logic        wr_en;
  logic        wr_ctrl;
  logic        wr_qsel;
  logic        wr_func;
  logic        mapped;
  logic [31:0] rd_mux;

  logic [31:0] port_ctrl_reg;
  logic [31:0] qsel_reg;
  logic [31:0] func_reg;
  logic [31:0] qsel_pipe [gpio_qual_pkg::APPLY_DELAY];
  logic [31:0] func_pipe [gpio_qual_pkg::APPLY_DELAY];
  logic [31:0] qsel_active;
  logic [15:0] level;
  logic [gpio_qual_pkg::GROUP_COUNT-1:0] strobe;

  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite;
  assign wr_ctrl = wr_en & (paddr == gpio_qual_pkg::OFS_PORT_CTRL);
  assign wr_qsel = wr_en & (paddr == gpio_qual_pkg::OFS_QSEL);
  assign wr_func = wr_en & (paddr == gpio_qual_pkg::OFS_FUNC);
  assign mapped  = (paddr == gpio_qual_pkg::OFS_PORT_CTRL) | (paddr == gpio_qual_pkg::OFS_QSEL) |
                   (paddr == gpio_qual_pkg::OFS_FUNC) | (paddr == gpio_qual_pkg::OFS_LEVEL);

  // zero wait states: read data is registered in setup, so ready can sit high
  assign pready = 1'b1;

  // read selection, unmapped reads as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      gpio_qual_pkg::OFS_PORT_CTRL: rd_mux = port_ctrl_reg;
      gpio_qual_pkg::OFS_QSEL:      rd_mux = qsel_reg;
      gpio_qual_pkg::OFS_FUNC:      rd_mux = func_reg;
      gpio_qual_pkg::OFS_LEVEL:     rd_mux = {16'h0000, pin_qualified};
      default:                      rd_mux = 32'h0000_0000;
    endcase
  end

  // read data and error are registered during the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= ~mapped;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_ctrl_reg <= gpio_qual_pkg::RST_PORT_CTRL;
      qsel_reg      <= gpio_qual_pkg::RST_QSEL;
      func_reg      <= gpio_qual_pkg::RST_FUNC;
    end else begin
      if (wr_ctrl) port_ctrl_reg <= {16'h0000, pwdata[15:0]};
      if (wr_qsel) qsel_reg <= pwdata;
      if (wr_func) func_reg <= pwdata;
    end
  end

  // apply delay: written values reach the pins two clocks later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < gpio_qual_pkg::APPLY_DELAY; i++) begin
        qsel_pipe[i] <= gpio_qual_pkg::RST_QSEL;
        func_pipe[i] <= gpio_qual_pkg::RST_FUNC;
      end
    end else begin
      qsel_pipe[0] <= wr_qsel ? pwdata : qsel_reg;
      func_pipe[0] <= wr_func ? pwdata : func_reg;
      for (int i = 1; i < gpio_qual_pkg::APPLY_DELAY; i++) begin
        qsel_pipe[i] <= qsel_pipe[i-1];
        func_pipe[i] <= func_pipe[i-1];
      end
    end
  end

  assign qsel_active  = qsel_pipe[gpio_qual_pkg::APPLY_DELAY-1];
  assign pin_function = func_pipe[gpio_qual_pkg::APPLY_DELAY-1];

  // ----------------------------------------------------------------
  // group sample timers
  // ----------------------------------------------------------------
  for (genvar g = 0; g < gpio_qual_pkg::GROUP_COUNT; g++) begin : grp
    logic [7:0] field;
    logic [8:0] limit;
    logic [8:0] cnt_reg;
    logic [8:0] gap_reg;

    assign field = port_ctrl_reg[g*gpio_qual_pkg::FIELD_W +: gpio_qual_pkg::FIELD_W];
    assign limit = {field, 1'b0} - 9'h001;
    assign strobe[g] = (field == 8'h00) | (cnt_reg == limit);

    // a rewrite of the field restarts the interval, so no stale partial period
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_reg <= 9'h000;
      end else if (wr_ctrl || strobe[g]) begin
        cnt_reg <= 9'h000;
      end else begin
        cnt_reg <= cnt_reg + 9'h001;
      end
    end

    // check helper: cycles since last tick or restart
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        gap_reg <= 9'h000;
      end else if (wr_ctrl || strobe[g]) begin
        gap_reg <= 9'h000;
      end else begin
        gap_reg <= gap_reg + 9'h001;
      end
    end

    property p_zero_every;
      @(posedge pclk) disable iff (!presetn)
        (field == 8'h00) |-> strobe[g];
    endproperty
    a_zero_every: assert property (p_zero_every) else $error("zero period must sample every clock");

    property p_interval;
      @(posedge pclk) disable iff (!presetn)
        (strobe[g] && field != 8'h00) |-> (gap_reg == {field, 1'b0} - 9'h001);
    endproperty
    a_interval: assert property (p_interval) else $error("sample interval is not twice the field");

    property p_restart;
      @(posedge pclk) disable iff (!presetn)
        (wr_ctrl && pwdata[g*8 +: 8] != 8'h00) |=> (!strobe[g] && cnt_reg == 9'h000);
    endproperty
    a_restart: assert property (p_restart) else $error("field write did not restart timer");
  end

  // ----------------------------------------------------------------
  // per-pin qualifier cells
  // ----------------------------------------------------------------
  for (genvar p = 0; p < gpio_qual_pkg::PIN_COUNT; p++) begin : pin
    input_qualifier_cell u_cell (
      .pclk          (pclk),
      .presetn       (presetn),
      .pin_raw       (pin_in[p]),
      .sample_strobe (strobe[p / gpio_qual_pkg::GROUP_SIZE]),
      .mode          (qsel_active[2*p +: 2]),
      .level_out     (level[p])
    );
  end

  assign pin_qualified = level;

  // ----------------------------------------------------------------
  // checks on the apply delay
  // ----------------------------------------------------------------
  sequence s_lone_qsel_write;
    wr_qsel ##1 !wr_qsel;
  endsequence

  sequence s_lone_func_write;
    wr_func ##1 !wr_func;
  endsequence

  property p_qsel_delay;
    @(posedge pclk) disable iff (!presetn)
      s_lone_qsel_write |-> ##1 (qsel_active == $past(pwdata, 2));
  endproperty
  a_qsel_delay: assert property (p_qsel_delay) else $error("qualifier select not applied two clocks later");

  property p_func_delay;
    @(posedge pclk) disable iff (!presetn)
      s_lone_func_write |-> ##1 (pin_function == $past(pwdata, 2));
  endproperty
  a_func_delay: assert property (p_func_delay) else $error("pin function not applied two clocks later");

  property p_not_early;
    @(posedge pclk) disable iff (!presetn)
      wr_func |=> $stable(pin_function);
  endproperty
  a_not_early: assert property (p_not_early) else $error("pin function applied too early");

endmodule

`default_nettype wire

// ---- hdl/gpio_qual_pkg.sv ----
// constants shared by the gpio input qualifier and its per-pin cell
// assumes one 25 mhz apb clock; pins arrive asynchronous to it
//
// Behaviour
// - pin-function and qualifier-select writes take effect two clocks after the write
// - sampling period field zero means one sample on every clock
// - nonzero sampling period field n means one sample every 2n clocks
// - sampling period field is eight bits, any value 0 to 0xff
// - one sampling period field serves a group of eight consecutive pins
// - per pin, qualifier select picks a three or six sample window
// - three sample window spans two sampling periods
// - six sample window spans five sampling periods
// - in the three and six sample modes, qualified level changes only when all window samples agree
// - qualifier select both ones passes the raw pin, unsynchronised
`default_nettype none

package gpio_qual_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int PIN_COUNT   = 16;
  localparam int GROUP_SIZE  = 8;
  localparam int GROUP_COUNT = 2;
  localparam int FIELD_W     = 8;
  localparam int WINDOW_MAX  = 6;
  localparam int ADDR_W      = 8;

  // ----------------------------------------------------------------
  // register byte offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_PORT_CTRL = 8'h00;
  localparam logic [7:0]  OFS_QSEL      = 8'h04;
  localparam logic [7:0]  OFS_FUNC      = 8'h08;
  localparam logic [7:0]  OFS_LEVEL     = 8'h0c;
  localparam logic [31:0] RST_PORT_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_QSEL      = 32'h0000_0000;
  localparam logic [31:0] RST_FUNC      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // qualifier modes, two bits per pin
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_SYNC  = 2'h0;
  localparam logic [1:0] MODE_THREE = 2'h1;
  localparam logic [1:0] MODE_SIX   = 2'h2;
  localparam logic [1:0] MODE_ASYNC = 2'h3;

  // ----------------------------------------------------------------
  // timing, in clock cycles
  // ----------------------------------------------------------------
  localparam int APPLY_DELAY = 2;

endpackage

`default_nettype wire

// ---- hdl/input_qualifier_cell.sv ----
// one pin: two-flop synchroniser, sample window and qualified level
// assumes sample_strobe and mode come from logic on pclk
`timescale 1ns/1ps
`default_nettype none

module input_qualifier_cell (
  input  wire logic       pclk,          // system clock
  input  wire logic       presetn,       // async reset, active low
  input  wire logic       pin_raw,       // asynchronous pin level
  input  wire logic       sample_strobe, // one-cycle sample tick of the group
  input  wire logic [1:0] mode,          // qualifier select of this pin
  output logic            level_out      // qualified level
);

  logic       sync_a_reg;
  logic       sync_b_reg;
  logic [5:0] window_reg;
  logic       level_reg;
  logic       all3;
  logic       all6;

  // ----------------------------------------------------------------
  // synchroniser, first flop feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a_reg <= 1'b0;
      sync_b_reg <= 1'b0;
    end else begin
      sync_a_reg <= pin_raw;
      sync_b_reg <= sync_a_reg;
    end
  end

  // sample history, newest in bit 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      window_reg <= 6'h00;
    end else if (sample_strobe) begin
      window_reg <= {window_reg[4:0], sync_b_reg};
    end
  end

  // agreement of the newest three or six samples
  assign all3 = (&window_reg[2:0]) | ~(|window_reg[2:0]);
  assign all6 = (&window_reg) | ~(|window_reg);

  // qualified level; a split window holds the old value so glitches die here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg <= 1'b0;
    end else begin
      case (mode)
        gpio_qual_pkg::MODE_SYNC: begin
          level_reg <= sync_b_reg;
        end
        gpio_qual_pkg::MODE_THREE: begin
          if (all3) begin
            level_reg <= window_reg[0];
          end
        end
        gpio_qual_pkg::MODE_SIX: begin
          if (all6) begin
            level_reg <= window_reg[0];
          end
        end
        default: begin
          level_reg <= level_reg;
        end
      endcase
    end
  end

  // bypass for peripherals that synchronise on their own
  assign level_out = (mode == gpio_qual_pkg::MODE_ASYNC) ? pin_raw : level_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // four clean cycles out of reset: the flops hold reset zeros until then, not the pin
  sequence s_sync_steady;
    (presetn && mode == gpio_qual_pkg::MODE_SYNC) [*4];
  endsequence

  property p_sync_latency;
    @(posedge pclk) disable iff (!presetn)
      s_sync_steady |-> (level_reg == $past(pin_raw, 3));
  endproperty
  a_sync_latency: assert property (p_sync_latency) else $error("sync mode latency wrong");

  property p_three_hold;
    @(posedge pclk) disable iff (!presetn)
      (mode == gpio_qual_pkg::MODE_THREE && $past(mode) == gpio_qual_pkg::MODE_THREE && !$past(all3))
        |-> (level_reg == $past(level_reg));
  endproperty
  a_three_hold: assert property (p_three_hold) else $error("three window changed on split samples");

  property p_six_hold;
    @(posedge pclk) disable iff (!presetn)
      (mode == gpio_qual_pkg::MODE_SIX && $past(mode) == gpio_qual_pkg::MODE_SIX && !$past(all6))
        |-> (level_reg == $past(level_reg));
  endproperty
  a_six_hold: assert property (p_six_hold) else $error("six window changed on split samples");

  property p_three_take;
    @(posedge pclk) disable iff (!presetn)
      (mode == gpio_qual_pkg::MODE_THREE && all3) |=> (level_reg == $past(window_reg[0]));
  endproperty
  a_three_take: assert property (p_three_take) else $error("three window agreement not taken");

  property p_six_take;
    @(posedge pclk) disable iff (!presetn)
      (mode == gpio_qual_pkg::MODE_SIX && all6) |=> (level_reg == $past(window_reg[0]));
  endproperty
  a_six_take: assert property (p_six_take) else $error("six window agreement not taken");

  property p_bypass;
    @(posedge pclk) disable iff (!presetn)
      (mode == gpio_qual_pkg::MODE_ASYNC) |-> (level_out == pin_raw);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass does not pass raw pin");

endmodule

`default_nettype wire
